// ==== bench/sotp_access_tb.sv ====
// Self-checking bench for the secured OTP access block.
// Assumes sotp_host as serial master and a main array answering combinationally.
`timescale 1ns/100ps
module sotp_access_tb;
  import sotp_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic factory = 1'b0;
  logic sck, cs_n, mosi, miso, miso_line, miso_oe_n, main_we, main_erase, sr_we, sr_sel, otp_mode;
  logic [23:0] main_addr;
  logic [7:0] main_wdata, lock_status, main_rdata;
  logic [39:0] q_port[$];
  logic [23:0] q_rd[$];
  int n_errors = 0;
  int total_checks = 0;
  logic [23:0] a;
  logic [7:0] d0, d1;
  int seed;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  // Main array stand-in: data follows the address
  assign main_rdata = main_addr[7:0] ^ 8'h5a;
  // Released data line shows the inverse, so an undriven bit cannot match
  assign miso_line = miso_oe_n ? ~miso : miso;

  sotp_host i_host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_line));

  sotp_access i_dut (.I_CLK_SYS(clk_sys), .I_NRST(nrst), .I_SCK(sck), .I_CS_N(cs_n), .I_MOSI(mosi),
    .O_MISO(miso), .O_MISO_OE_N(miso_oe_n), .I_FACTORY_LOCK(factory), .O_MAIN_ADDR(main_addr),
    .O_MAIN_WDATA(main_wdata), .O_MAIN_WE(main_we), .O_MAIN_ERASE(main_erase), .I_MAIN_RDATA(main_rdata),
    .O_SR_WE(sr_we), .O_SR_SEL(sr_sel), .O_OTP_MODE(otp_mode), .O_LOCK_STATUS(lock_status));

  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic do_reset(input logic f);
    @(negedge clk_sys);
    nrst <= 1'b0;
    factory <= f;
    repeat (2) @(negedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic wren();
    i_host.xfer({OP_WREN, 56'h0}, 8, 1'b0);
  endtask

  task automatic pgm(input logic [23:0] ad, input logic [7:0] x0, input logic [7:0] x1);
    wren();
    i_host.xfer({OP_PROG, ad, x0, x1, 16'h0}, 48, 1'b0);
  endtask

  task automatic rd3(input logic [23:0] ad, input logic [23:0] exp);
    q_rd.push_back(exp);
    i_host.xfer({OP_READ, ad, 32'h0}, 56, 1'b1);
  endtask

  task automatic wrlock(input logic [7:0] v, input int nbits);
    i_host.xfer({OP_WR_LOCK, v, 48'h0}, nbits, 1'b0);
  endtask

  // Write pulses: each one consumes the oldest note
  always @(negedge clk_sys) begin
    if (nrst && (main_we | main_erase | sr_we)) begin
      if (q_port.size() == 0) begin
        check("unexpected_pulse", 40'h0, {main_we, main_erase, sr_we, 37'h0});
      end else begin
        check("write_pulse", q_port.pop_front(), {main_we, main_erase, sr_we, sr_we & sr_sel, 4'h0,
          (main_we | main_erase) ? main_addr : 24'h0, (main_we | sr_we) ? main_wdata : 8'h0});
      end
    end
  end

  // Read frames: each one consumes the oldest read note
  always begin
    @(i_host.rd_done);
    if (q_rd.size() == 0) begin
      check("unexpected_read", 40'h1, 40'h0);
    end else begin
      check("read_data", {16'h0, q_rd.pop_front()}, {16'h0, i_host.rd_word});
    end
  end

  // Hang guard
  initial begin
    #300000;
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    seed = $urandom(32'hbc07);
    do_reset(1'b0);
    check("lock_reset", 40'h0, {32'h0, lock_status});
    check("oe_idle", 40'h1, {39'h0, miso_oe_n});
    q_rd.push_back(24'h0);
    i_host.xfer({OP_RD_LOCK, 56'h0}, 32, 1'b1);
    // Main program ignored after write disable, then accepted
    a = {8'h00, 16'($urandom())};
    d0 = 8'($urandom());
    d1 = 8'($urandom());
    wren();
    i_host.xfer({OP_WRDI, 56'h0}, 8, 1'b0);
    i_host.xfer({OP_PROG, a, d0, d1, 16'h0}, 48, 1'b0);
    q_port.push_back({4'h8, 4'h0, a, d0});
    q_port.push_back({4'h8, 4'h0, a + 24'h1, d1});
    pgm(a, d0, d1);
    // Both status writes pass outside OTP mode
    for (int i = 0; i < 2; i++) begin
      q_port.push_back({3'b001, 1'(i), 4'h0, 24'h0, d0});
      wren();
      i_host.xfer({(i != 0) ? OP_WRSR2 : OP_WRSR1, d0, 48'h0}, 16, 1'b0);
    end
    i_host.xfer({OP_OTP_ENTER, 56'h0}, 8, 1'b0);
    check("otp_mode_on", 40'h1, {39'h0, otp_mode});
    for (int i = 0; i < 2; i++) begin
      wren();
      i_host.xfer({(i != 0) ? OP_WRSR2 : OP_WRSR1, d0, 48'h0}, 16, 1'b0);
    end
    wrlock(8'h02, 16);
    check("lock_in_otp", 40'h0, {32'h0, lock_status});
    pgm(24'h00000f, d0, d1);
    wren();
    i_host.xfer({OP_ERASE, 24'h00000f, 32'h0}, 32, 1'b0);
    rd3(24'h00000f, {d0, d1, OTP_BLANK});
    i_host.xfer({OP_OTP_EXIT, 56'h0}, 8, 1'b0);
    check("otp_mode_off", 40'h0, {39'h0, otp_mode});
    rd3(a, {a[7:0] ^ 8'h5a, (a[7:0] + 8'h1) ^ 8'h5a, (a[7:0] + 8'h2) ^ 8'h5a});
    // Main erase reaches the array again outside OTP mode
    q_port.push_back({4'h4, 4'h0, a, 8'h00});
    wren();
    i_host.xfer({OP_ERASE, a, 32'h0}, 32, 1'b0);
    // Lock write off the byte boundary is dropped
    for (int n = 15; n <= 17; n += 2) begin
      wrlock(8'h02, n);
    end
    check("lock_partial", 40'h0, {32'h0, lock_status});
    wrlock(8'hfe, 16);
    check("lock_set", 40'h2, {32'h0, lock_status});
    wrlock(8'h00, 16);
    check("lock_sticky", 40'h2, {32'h0, lock_status});
    // Locked region refuses programming
    i_host.xfer({OP_OTP_ENTER, 56'h0}, 8, 1'b0);
    pgm(24'h000020, 8'h00, 8'h00);
    rd3(24'h00001f, 24'hffffff);
    i_host.xfer({OP_OTP_EXIT, 56'h0}, 8, 1'b0);
    // Fresh part with the factory strap set
    do_reset(1'b1);
    check("factory_bit", 40'h1, {32'h0, lock_status});
    wrlock(8'h00, 16);
    q_rd.push_back(24'h010101);
    i_host.xfer({OP_RD_LOCK, 56'h0}, 32, 1'b1);
    for (int i = 0; i < 100 && (q_port.size() + q_rd.size()) != 0; i++) begin
      @(negedge clk_sys);
    end
    check("notes_left", 40'h0, 40'(q_port.size() + q_rd.size()));
    report_and_stop();
  end
endmodule

// ==== bench/sotp_host.sv ====
// Serial host model that drives command frames into the secured OTP block.
// Assumes mode 0: SCK low and still between frames, 64 ns SCK period.
`timescale 1ns/100ps
module sotp_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  logic [23:0] rd_word;
  event rd_done;

  // Idle levels before the first frame
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    rd_word = 24'h0;
  end

  // One frame: shift tx MSB first, capture MISO on each rising edge
  task automatic xfer(input logic [63:0] tx, input int nbits, input bit want);
    logic [63:0] sh;
    logic [23:0] rx;
    sh = tx;
    rx = 24'h0;
    // Odd offset keeps SCK edges off the system clock edges
    #13;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_mosi = sh[63];
      sh = {sh[62:0], 1'b0};
      #32 o_sck = 1'b1;
      rx = {rx[22:0], i_miso};
      #32 o_sck = 1'b0;
    end
    #8 o_cs_n = 1'b1;
    // Idle data line shows the inverse of the last bit
    o_mosi = ~o_mosi;
    rd_word = rx;
    if (want) begin
      ->rd_done;
    end
    // Frame gap, with the offset it rounds the frame to whole clocks
    #187;
  endtask
endmodule

// ==== logic/sotp_access.sv ====
// Secured OTP access control with its lock-status register.
// Assumes a mode-0/3 serial host, SCK period 64 ns or more, and
// chip-select held high at least 8 ns after the last rising SCK edge.
`timescale 1ns/100ps
// Functional notes
// - Enter opcode switches reads/programs to OTP
// - Exit opcode returns access to main array
// - OTP is 4 kbit, separate from main
// - Status and lock writes refused in OTP
// - Locked region accepts reads only
// - No main array writes in OTP mode
// - Lock status readable anytime, repeated
// - Bit 0 is read-only factory lock
// - Bit 1 lockdown sets once, freezes all OTP programming
// - Lock write needs no write enable
// - Lock write only on byte boundary
module sotp_access (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_MOSI,
  output logic O_MISO,
  output logic O_MISO_OE_N,
  input wire logic I_FACTORY_LOCK,
  output logic [23:0] O_MAIN_ADDR,
  output logic [7:0] O_MAIN_WDATA,
  output logic O_MAIN_WE,
  output logic O_MAIN_ERASE,
  input wire logic [7:0] I_MAIN_RDATA,
  output logic O_SR_WE,
  output logic O_SR_SEL,
  output logic O_OTP_MODE,
  output logic [7:0] O_LOCK_STATUS
);
  import sotp_pkg::*;
  // Phase that follows a command byte
  function automatic sotp_phase_e cmd_phase(input logic [7:0] op);
    if (op == OP_READ || op == OP_PROG || op == OP_ERASE) begin
      return PH_ADDR;
    end else if (op == OP_RD_LOCK || op == OP_WR_LOCK || op == OP_WRSR1 || op == OP_WRSR2) begin
      return PH_DATA;
    end
    return PH_SKIP;
  endfunction

  logic link_nrst, lk_byte_tg, lk_bit_tg, lk_tx_on, tx_drive;
  logic [2:0] lk_bit;
  logic [7:0] lk_sh, lk_byte, lk_tx, tx_byte;

  // Frame logic is cleared whenever chip-select is high
  assign link_nrst = I_NRST & ~I_CS_N;

  // Bit counter and input shifter on rising SCK
  always_ff @(posedge I_SCK or negedge link_nrst) begin
    if (!link_nrst) begin
      lk_bit <= 3'h0;
      lk_sh <= 8'h00;
    end else begin
      lk_bit <= lk_bit + 3'h1;
      lk_sh <= {lk_sh[6:0], I_MOSI};
    end
  end

  // Completed bytes and toggles that hand events to the system clock
  always_ff @(posedge I_SCK or negedge I_NRST) begin
    if (!I_NRST) begin
      lk_byte <= 8'h00;
      lk_byte_tg <= 1'b0;
      lk_bit_tg <= 1'b0;
    end else begin
      lk_bit_tg <= ~lk_bit_tg;
      if (lk_bit == BIT_LAST) begin
        lk_byte <= {lk_sh[6:0], I_MOSI};
        lk_byte_tg <= ~lk_byte_tg;
      end
    end
  end

  // Output shifter on falling SCK, loads at each byte boundary
  always_ff @(negedge I_SCK or negedge link_nrst) begin
    if (!link_nrst) begin
      lk_tx <= 8'h00;
      lk_tx_on <= 1'b0;
    end else if (lk_bit == 3'h0) begin
      lk_tx <= tx_byte;
      lk_tx_on <= tx_drive;
    end else begin
      lk_tx <= {lk_tx[6:0], 1'b0};
    end
  end

  assign O_MISO = lk_tx[7];
  assign O_MISO_OE_N = ~lk_tx_on;

  logic cs_n_s, byte_tg_s, bit_tg_s, fl_s, cs_n_d, byte_tg_d, bit_tg_d;
  logic byte_evt, bit_evt, frame_end;
  logic [7:0] rx;

  // Crossings into the system clock
  sotp_sync #(.RST_VAL(1'b1)) u_cs (.i_clk(I_CLK_SYS), .i_nrst(I_NRST), .i_d(I_CS_N), .o_q(cs_n_s));
  sotp_sync u_byte (.i_clk(I_CLK_SYS), .i_nrst(I_NRST), .i_d(lk_byte_tg), .o_q(byte_tg_s));
  sotp_sync u_bit (.i_clk(I_CLK_SYS), .i_nrst(I_NRST), .i_d(lk_bit_tg), .o_q(bit_tg_s));
  sotp_sync u_fl (.i_clk(I_CLK_SYS), .i_nrst(I_NRST), .i_d(I_FACTORY_LOCK), .o_q(fl_s));

  // Edge detectors on synchronised signals
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cs_n_d <= 1'b1;
      byte_tg_d <= 1'b0;
      bit_tg_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      byte_tg_d <= byte_tg_s;
      bit_tg_d <= bit_tg_s;
    end
  end

  assign byte_evt = byte_tg_s ^ byte_tg_d;
  assign bit_evt = bit_tg_s ^ bit_tg_d;
  assign frame_end = cs_n_s & ~cs_n_d;
  // Byte is stable until the next toggle
  assign rx = lk_byte;

  sotp_phase_e phase;
  logic [7:0] cmd, wdata, otp_rd, lock_st;
  logic [2:0] nbyte, sbits;
  logic [23:0] addr;
  logic [1:0] fl_cnt;
  logic adv, otp_mode, wel, lockdown, factory, otp_we;
  logic otp_locked, otp_in_range, data_byte, wls_ok;

  assign lock_st = {LS_RSVD, lockdown, factory};
  assign otp_locked = lockdown | factory;
  // 0x000-0x1ff: serial number then user space
  assign otp_in_range = (addr[23:OTP_AW] == 15'h0000) && (addr[OTP_AW-1:0] <= USER_LAST);
  assign data_byte = byte_evt && phase == PH_DATA;
  // whole bytes, exactly one data byte
  assign wls_ok = frame_end && cmd == OP_WR_LOCK && phase == PH_DATA && sbits == 3'h0 && nbyte == 3'h1
    && !otp_mode && wdata[LS_LOCKDOWN];

  // Command phase tracking
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      phase <= PH_CMD;
      cmd <= 8'h00;
      nbyte <= 3'h0;
    end else if (frame_end) begin
      phase <= PH_CMD;
    end else if (byte_evt) begin
      unique case (phase)
        PH_CMD: begin
          cmd <= rx;
          phase <= cmd_phase(rx);
          nbyte <= 3'h0;
        end
        PH_ADDR: begin
          nbyte <= nbyte + 3'h1;
          if (nbyte == ADDR_LAST) begin
            phase <= PH_DATA;
            nbyte <= 3'h0;
          end
        end
        PH_DATA: begin
          if (nbyte != NBYTE_MAX) begin
            nbyte <= nbyte + 3'h1;
          end
        end
        PH_SKIP: begin
        end
      endcase
    end
  end

  // Bit count within the frame, for the boundary check
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      sbits <= 3'h0;
    end else if (frame_end) begin
      sbits <= 3'h0;
    end else if (bit_evt) begin
      sbits <= sbits + 3'h1;
    end
  end

  // Address load and advance after each read or program data byte
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      addr <= 24'h000000;
      adv <= 1'b0;
    end else begin
      adv <= data_byte && (cmd == OP_READ || cmd == OP_PROG);
      if (byte_evt && phase == PH_ADDR) begin
        addr <= {addr[15:0], rx};
      end else if (adv) begin
        addr <= addr + 24'h000001;
      end
    end
  end

  // Mode switching on enter and exit opcodes
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      otp_mode <= 1'b0;
    end else if (byte_evt && phase == PH_CMD) begin
      if (rx == OP_OTP_ENTER) begin
        otp_mode <= 1'b1;
      end else if (rx == OP_OTP_EXIT) begin
        otp_mode <= 1'b0;
      end
    end
  end

  // Write enable latch for program, erase and status writes
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      wel <= 1'b0;
    end else if (byte_evt && phase == PH_CMD && rx == OP_WREN) begin
      wel <= 1'b1;
    end else if (byte_evt && phase == PH_CMD && rx == OP_WRDI) begin
      wel <= 1'b0;
    end else if (frame_end && phase != PH_CMD && cmd_phase(cmd) != PH_SKIP && cmd != OP_RD_LOCK
      && cmd != OP_READ && cmd != OP_WR_LOCK) begin
      wel <= 1'b0;
    end
  end

  // Factory lock strap caught once after reset release
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      fl_cnt <= 2'h0;
      factory <= 1'b0;
    end else if (fl_cnt != STRAP_SETTLE) begin
      fl_cnt <= fl_cnt + 2'h1;
      if (fl_cnt == STRAP_SETTLE - 2'h1) begin
        factory <= fl_s;
      end
    end
  end

  // Customer lockdown bit, set once and never cleared
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      lockdown <= 1'b0;
    end else if (wls_ok) begin
      lockdown <= 1'b1;
    end
  end

  // Write strobes towards both arrays and the status register
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      wdata <= 8'h00;
      otp_we <= 1'b0;
      O_MAIN_WE <= 1'b0;
      O_MAIN_ERASE <= 1'b0;
      O_SR_WE <= 1'b0;
      O_SR_SEL <= 1'b0;
    end else begin
      if (data_byte) begin
        wdata <= rx;
      end
      otp_we <= data_byte && cmd == OP_PROG && otp_mode && wel && !otp_locked && otp_in_range;
      // main writes blocked in OTP mode
      O_MAIN_WE <= data_byte && cmd == OP_PROG && !otp_mode && wel;
      O_MAIN_ERASE <= frame_end && cmd == OP_ERASE && phase == PH_DATA && !otp_mode && wel;
      // status writes refused in OTP mode
      O_SR_WE <= frame_end && (cmd == OP_WRSR1 || cmd == OP_WRSR2) && phase == PH_DATA && nbyte != 3'h0
        && !otp_mode && wel;
      O_SR_SEL <= cmd == OP_WRSR2;
    end
  end

  assign O_MAIN_ADDR = addr;
  assign O_MAIN_WDATA = wdata;
  assign O_OTP_MODE = otp_mode;
  assign O_LOCK_STATUS = lock_st;

  sotp_otp_mem u_otp (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_we(otp_we),
    .i_addr(addr[OTP_AW-1:0]),
    .i_wdata(wdata),
    .o_rdata(otp_rd)
  );

  // Next byte for the output shifter, held stable between boundaries
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_byte <= 8'h00;
      tx_drive <= 1'b0;
    end else begin
      tx_drive <= phase == PH_DATA && (cmd == OP_READ || cmd == OP_RD_LOCK);
      if (cmd == OP_RD_LOCK) begin
        tx_byte <= lock_st;
      end else if (otp_mode) begin
        tx_byte <= otp_in_range ? otp_rd : OTP_BLANK;
      end else begin
        tx_byte <= I_MAIN_RDATA;
      end
    end
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);

  property p_enter;
    byte_evt && phase == PH_CMD && rx == OP_OTP_ENTER |=> otp_mode [*2];
  endproperty
  a_enter: assert property (p_enter) else $error("enter opcode did not set OTP mode");
  property p_exit;
    byte_evt && phase == PH_CMD && rx == OP_OTP_EXIT |=> !otp_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("exit opcode did not clear OTP mode");
  property p_sr_block;
    O_SR_WE |-> !otp_mode && $past(wel);
  endproperty
  a_sr_block: assert property (p_sr_block) else $error("status write in OTP mode");
  property p_locked;
    otp_we |-> !$past(otp_locked) && otp_mode;
  endproperty
  a_locked: assert property (p_locked) else $error("locked OTP was programmed");
  property p_no_main;
    O_MAIN_WE || O_MAIN_ERASE |-> !$past(otp_mode);
  endproperty
  a_no_main: assert property (p_no_main) else $error("main write during OTP mode");
  property p_rdls;
    phase == PH_DATA && cmd == OP_RD_LOCK |=> tx_byte == $past(lock_st) && tx_drive;
  endproperty
  a_rdls: assert property (p_rdls) else $error("lock status not presented");
  property p_factory;
    fl_cnt == STRAP_SETTLE |=> $stable(factory) && O_LOCK_STATUS[7:2] == LS_RSVD;
  endproperty
  a_factory: assert property (p_factory) else $error("factory lock or reserved bits changed");
  property p_lock_once;
    lockdown |=> lockdown;
  endproperty
  a_lock_once: assert property (p_lock_once) else $error("lockdown bit cleared");
  property p_no_wel;
    frame_end && cmd == OP_WR_LOCK && phase == PH_DATA && sbits == 3'h0 && nbyte == 3'h1 && !otp_mode
      && wdata[LS_LOCKDOWN] && !wel |=> lockdown;
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("lock write ignored");
  property p_boundary;
    frame_end && sbits != 3'h0 && !lockdown |=> !lockdown;
  endproperty
  a_boundary: assert property (p_boundary) else $error("lock write on partial byte");
  property p_range;
    otp_we |-> addr[23:OTP_AW] == 15'h0000;
  endproperty
  a_range: assert property (p_range) else $error("OTP write outside region");
  c_enter: cover property (byte_evt && phase == PH_CMD && rx == OP_OTP_ENTER);
  c_otp_prog: cover property (otp_we);
  c_lockdown: cover property ($rose(lockdown));
  c_rdls: cover property (tx_drive && cmd == OP_RD_LOCK);
endmodule

// ==== logic/sotp_otp_mem.sv ====
// One-time-programmable byte array of the secured region.
// Assumes the caller gates writes; programming can only clear bits.
`timescale 1ns/100ps
module sotp_otp_mem (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_we,
  input wire logic [sotp_pkg::OTP_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  import sotp_pkg::*;
  logic [7:0] mem [OTP_BYTES];

  // Blank after reset, program clears bits only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < OTP_BYTES; i++) begin
        mem[i] <= OTP_BLANK;
      end
    end else if (i_we) begin
      mem[i_addr] <= mem[i_addr] & i_wdata;
    end
  end

  // Read port
  assign o_rdata = mem[i_addr];
endmodule

// ==== logic/sotp_pkg.sv ====
// Constants shared by the secured OTP access block.
// Assumes a serial host driving 8-bit commands, MSB first.
package sotp_pkg;
  // Command opcodes
  localparam logic [7:0] OP_OTP_ENTER = 8'hb1;
  localparam logic [7:0] OP_OTP_EXIT = 8'hc1;
  localparam logic [7:0] OP_RD_LOCK = 8'h2b;
  localparam logic [7:0] OP_WR_LOCK = 8'h2f;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  // OTP region: 4 kbit as 512 bytes
  localparam int OTP_BYTES = 512;
  localparam int OTP_AW = 9;
  localparam logic [8:0] ESN_LAST = 9'h00f;
  localparam logic [8:0] USER_LAST = 9'h1ff;
  localparam logic [7:0] OTP_BLANK = 8'hff;
  // Lock-status field positions and reserved value
  localparam int LS_FACTORY = 0;
  localparam int LS_LOCKDOWN = 1;
  localparam logic [5:0] LS_RSVD = 6'h00;
  // Frame counts
  localparam logic [2:0] ADDR_LAST = 3'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] NBYTE_MAX = 3'h7;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_SKIP} sotp_phase_e;
endpackage

// ==== logic/sotp_sync.sv ====
// Two-flop level synchroniser.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/100ps
module sotp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_d,
  output logic o_q
);
  logic meta;

  // First flop feeds only the second
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
